// [pkg/pcdc_regs.vh]
`ifndef PCDC_REGS_VH
`define PCDC_REGS_VH
`define PCDC_BASE0 32'h000F5400
`define PCDC_BASE1 32'h000F5800
`define PCDC_OFS_DATA 32'h00000100
`define PCDC_OFS_CFG 32'h00000104
`define PCDC_OFS_STAT 32'h00000108
`define PCDC_OFS_COUNT 32'h0000010C
`define PCDC_CFG_THR_HI 7
`define PCDC_CFG_THR_LO 6
`define PCDC_CFG_TEN 5
`define PCDC_CFG_TB_HI 4
`define PCDC_CFG_TB_LO 3
`define PCDC_CFG_TRST 2
`define PCDC_CFG_FLUSH 1
`define PCDC_STAT_OVR 1
`define PCDC_STAT_NE 0
`define PCDC_CFG_RESET 5'h00
`define PCDC_TS_RESET 24'h000000
`define PCDC_THR_C0 5'h01
`define PCDC_THR_C1 5'h04
`define PCDC_THR_C2 5'h08
`define PCDC_THR_C3 5'h0E
`define PCDC_DIV_LAST0 6'h07
`define PCDC_DIV_LAST1 6'h0F
`define PCDC_DIV_LAST2 6'h1F
`define PCDC_DIV_LAST3 6'h3F
`endif

// [design/pcdc_capture.v]
`timescale 1ns/10ps
`default_nettype none
`include "pcdc_regs.vh"

// plain synchronous fifo; a pop and a push may share a cycle even when full
module pcdc_fifo #(
   parameter W = 32,
   parameter AW = 4
) (
   input wire sys_clk, // system clock
   input wire rstn, // sync reset, active low
   input wire ce, // clock enable
   input wire flush, // empty the fifo
   input wire in_valid, // push request
   output wire in_ready, // room for a push
   input wire [W-1:0] in_data, // push data
   output wire out_valid, // entry available
   input wire out_ready, // pop request
   output wire [W-1:0] out_data, // oldest entry
   output wire [AW:0] fill // entries held
);
   localparam DEPTH = 1 << AW;
   localparam [AW:0] FULL_CNT = DEPTH[AW:0];
   reg [W-1:0] mem_q [0:DEPTH-1];
   reg [AW-1:0] wr_q;
   reg [AW-1:0] rd_q;
   reg [AW:0] cnt_q;
   wire push;
   wire pop;
   integer i;

   // a full fifo still takes a push if the oldest entry leaves at once
   assign in_ready = (cnt_q != FULL_CNT) | out_ready;
   assign out_valid = (cnt_q != {(AW+1){1'b0}});
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_q[rd_q];
   assign fill = cnt_q;

   // pointers and count; flush outranks any push in the same cycle
   always @(posedge sys_clk) begin
      if (!rstn) begin
         wr_q <= {AW{1'b0}};
         rd_q <= {AW{1'b0}};
         cnt_q <= {(AW+1){1'b0}};
         for (i = 0; i < DEPTH; i = i + 1) begin
            mem_q[i] <= {W{1'b0}};
         end
      end else if (ce) begin
         if (flush) begin
            wr_q <= {AW{1'b0}};
            rd_q <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
         end else begin
            if (push) begin
               mem_q[wr_q] <= in_data;
               wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
               rd_q <= rd_q + 1'b1;
            end
            if (push & !pop) begin
               cnt_q <= cnt_q + 1'b1;
            end else if (pop & !push) begin
               cnt_q <= cnt_q - 1'b1;
            end
         end
      end
   end
endmodule

// one capture port: host byte queue, timestamp timer, ec registers
module pcdc_chan #(
   parameter [31:0] BASE_ADDR = `PCDC_BASE0,
   parameter AW = 4
) (
   input wire sys_clk, // system clock
   input wire rstn, // sync reset, active low
   input wire ce, // clock enable
   input wire ring_tick, // one pulse per 48 MHz oscillator period
   input wire activate, // port enable
   input wire host_wr, // host data write strobe
   input wire [7:0] host_data, // host byte
   output wire [7:0] host_rdata, // host data read value
   input wire [31:0] reg_addr, // ec byte address
   input wire reg_wr, // ec write strobe
   input wire reg_rd, // ec read strobe
   input wire [31:0] reg_wdata, // ec write data
   output wire [31:0] reg_rdata, // ec read data
   output wire reg_ack, // access hit this port
   output wire fill_level_irq // fifo at or above threshold
);
   reg [4:0] cfg_q;
   reg [23:0] ts_q;
   reg [5:0] div_q;
   reg ovr_q;
   reg [31:0] rdata_q;
   reg ack_q;
   reg irq_q;
   wire hit_data;
   wire hit_cfg;
   wire hit_stat;
   wire hit_cnt;
   wire cfg_wr;
   wire flush;
   wire ts_clr;
   wire ts_load;
   wire tick;
   wire ec_pop;
   wire drop_old;
   wire out_valid;
   wire [31:0] out_data;
   wire [AW:0] fill;
   wire [1:0] thr_sel;
   wire [1:0] tb_sel;
   wire host_take;
   wire full;

   // irq fill level for a threshold code
   function [4:0] thr_level;
      input [1:0] code;
      begin
         case (code)
            2'h0: thr_level = `PCDC_THR_C0;
            2'h1: thr_level = `PCDC_THR_C1;
            2'h2: thr_level = `PCDC_THR_C2;
            default: thr_level = `PCDC_THR_C3;
         endcase
      end
   endfunction

   // last prescaler count for a timebase code
   function [5:0] div_last;
      input [1:0] code;
      begin
         case (code)
            2'h0: div_last = `PCDC_DIV_LAST0;
            2'h1: div_last = `PCDC_DIV_LAST1;
            2'h2: div_last = `PCDC_DIV_LAST2;
            default: div_last = `PCDC_DIV_LAST3;
         endcase
      end
   endfunction

   // full address match against this port's base
   assign hit_data = (reg_addr == BASE_ADDR + `PCDC_OFS_DATA);
   assign hit_cfg = (reg_addr == BASE_ADDR + `PCDC_OFS_CFG);
   assign hit_stat = (reg_addr == BASE_ADDR + `PCDC_OFS_STAT);
   assign hit_cnt = (reg_addr == BASE_ADDR + `PCDC_OFS_COUNT);

   assign thr_sel = cfg_q[4:3];
   assign tb_sel = cfg_q[1:0];
   assign cfg_wr = reg_wr & hit_cfg;
   // inactive port is held flushed and timer-cleared
   assign flush = !activate | (cfg_wr & reg_wdata[`PCDC_CFG_FLUSH]);
   assign ts_clr = !activate | (cfg_wr & reg_wdata[`PCDC_CFG_TRST])
      | (reg_wr & hit_cnt & (reg_wdata[31:8] == 24'h000000));
   assign ts_load = reg_wr & hit_cnt;
   assign tick = activate & ring_tick & (div_q >= div_last(tb_sel));

   // fifo feed; host writes are not claimed while inactive
   assign host_take = host_wr & activate;
   // taken from the count alone; the fifo's ready would loop back here
   assign full = fill[AW];
   assign drop_old = host_take & full;
   assign ec_pop = reg_rd & hit_data & out_valid;
   assign host_rdata = 8'h00;

   pcdc_fifo #(
      .W(32),
      .AW(AW)
   ) u_fifo (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .ce(ce),
      .flush(flush),
      .in_valid(host_take),
      .in_ready(),
      .in_data({ts_q, host_data}),
      .out_valid(out_valid),
      .out_ready(ec_pop | drop_old),
      .out_data(out_data),
      .fill(fill)
   );

   // prescaler on oscillator ticks; stopped while inactive
   // wraps at or above the last count, so a slower-to-faster switch
   // does not run the prescaler all the way round
   always @(posedge sys_clk) begin
      if (!rstn) begin
         div_q <= 6'h00;
      end else if (ce) begin
         if (!activate) begin
            div_q <= 6'h00;
         end else if (ring_tick) begin
            div_q <= (div_q >= div_last(tb_sel)) ? 6'h00 : div_q + 6'h01;
         end
      end
   end

   // timestamp timer; clear outranks load outranks counting
   always @(posedge sys_clk) begin
      if (!rstn) begin
         ts_q <= `PCDC_TS_RESET;
      end else if (ce) begin
         if (ts_clr) begin
            ts_q <= `PCDC_TS_RESET;
         end else if (ts_load) begin
            ts_q <= reg_wdata[31:8];
         end else if (tick & cfg_q[2]) begin
            ts_q <= ts_q + 24'h000001;
         end
      end
   end

   // config keeps bits 7:3; strobe bits are never stored
   always @(posedge sys_clk) begin
      if (!rstn) begin
         cfg_q <= `PCDC_CFG_RESET;
      end else if (ce) begin
         if (cfg_wr) begin
            cfg_q <= reg_wdata[`PCDC_CFG_THR_HI:`PCDC_CFG_TB_LO];
         end
      end
   end

   // sticky overrun; cleared by flush, but a new overrun wins
   always @(posedge sys_clk) begin
      if (!rstn) begin
         ovr_q <= 1'b0;
      end else if (ce) begin
         if (drop_old) begin
            ovr_q <= 1'b1;
         end else if (flush) begin
            ovr_q <= 1'b0;
         end
      end
   end

   // registered read data and ack, one cycle after the strobe
   always @(posedge sys_clk) begin
      if (!rstn) begin
         rdata_q <= 32'h00000000;
         ack_q <= 1'b0;
      end else if (ce) begin
         ack_q <= (reg_rd | reg_wr) & (hit_data | hit_cfg | hit_stat | hit_cnt);
         if (reg_rd) begin
            if (hit_data) begin
               rdata_q <= out_valid ? out_data : 32'h00000000;
            end else if (hit_cfg) begin
               rdata_q <= {24'h000000, cfg_q, 3'h0};
            end else if (hit_stat) begin
               rdata_q <= {30'h00000000, ovr_q, out_valid};
            end else if (hit_cnt) begin
               rdata_q <= {ts_q, 8'h00};
            end else begin
               rdata_q <= 32'h00000000;
            end
         end else begin
            rdata_q <= 32'h00000000;
         end
      end
   end

   // irq only while the port is active
   always @(posedge sys_clk) begin
      if (!rstn) begin
         irq_q <= 1'b0;
      end else if (ce) begin
         irq_q <= activate & (fill >= thr_level(thr_sel));
      end
   end

   assign reg_rdata = rdata_q;
   assign reg_ack = ack_q;
   assign fill_level_irq = irq_q;
endmodule

// two independent ports on one ec register path
module pcdc_top (
   input wire sys_clk, // system clock, 200 MHz
   input wire rstn, // sync reset, active low
   input wire ce, // clock enable
   input wire ring_tick, // 48 MHz oscillator tick
   input wire activate0, // port 0 enable
   input wire host0_wr, // port 0 host write
   input wire [7:0] host0_data, // port 0 host byte
   output wire [7:0] host0_rdata, // port 0 host read value
   input wire activate1, // port 1 enable
   input wire host1_wr, // port 1 host write
   input wire [7:0] host1_data, // port 1 host byte
   output wire [7:0] host1_rdata, // port 1 host read value
   input wire [31:0] reg_addr, // ec byte address
   input wire reg_wr, // ec write strobe
   input wire reg_rd, // ec read strobe
   input wire [31:0] reg_wdata, // ec write data
   output wire [31:0] reg_rdata, // ec read data
   output wire reg_ack, // access hit a port
   output wire fill_level_irq0, // port 0 irq
   output wire fill_level_irq1 // port 1 irq
);
   wire [31:0] rdata0;
   wire [31:0] rdata1;
   wire ack0;
   wire ack1;

   pcdc_chan #(.BASE_ADDR(`PCDC_BASE0), .AW(4)) u_port0 (
      .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .ring_tick(ring_tick),
      .activate(activate0), .host_wr(host0_wr), .host_data(host0_data),
      .host_rdata(host0_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata0),
      .reg_ack(ack0), .fill_level_irq(fill_level_irq0)
   );

   pcdc_chan #(.BASE_ADDR(`PCDC_BASE1), .AW(4)) u_port1 (
      .sys_clk(sys_clk), .rstn(rstn), .ce(ce), .ring_tick(ring_tick),
      .activate(activate1), .host_wr(host1_wr), .host_data(host1_data),
      .host_rdata(host1_rdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(rdata1),
      .reg_ack(ack1), .fill_level_irq(fill_level_irq1)
   );

   // unhit port returns zero, so an or merges the answers
   assign reg_rdata = rdata0 | rdata1;
   assign reg_ack = ack0 | ack1;
endmodule
`default_nettype wire

// [sim/pcdc_checker.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pcdc_regs.vh"
// watches the ec register path, host reads and irq lines of both ports
module pcdc_checker (
   input wire logic sys_clk, // system clock
   input wire logic rstn, // sync reset, active low
   input wire logic ce, // clock enable
   input wire logic activate0, // port 0 enable
   input wire logic activate1, // port 1 enable
   input wire logic [31:0] reg_addr, // ec byte address
   input wire logic reg_wr, // ec write strobe
   input wire logic reg_rd, // ec read strobe
   input wire logic [31:0] reg_rdata, // ec read data
   input wire logic reg_ack, // access hit a port
   input wire logic [7:0] host0_rdata, // port 0 host read
   input wire logic [7:0] host1_rdata, // port 1 host read
   input wire logic fill_level_irq0, // port 0 irq
   input wire logic fill_level_irq1 // port 1 irq
);
   wire [31:0] ofs;
   wire hit;
   wire req;
   // address bit 11 tells the two bases apart
   assign ofs = reg_addr - (reg_addr[11] ? `PCDC_BASE1 : `PCDC_BASE0);
   assign hit = (ofs[31:4] == 28'h0000010) && (ofs[1:0] == 2'h0);
   assign req = ce && (reg_rd || reg_wr);

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_ack_on_hit: assert property (req && hit |=> reg_ack)
      else $error("mapped access not acknowledged");
   a_no_stray_ack: assert property (!(req && hit) |=> !reg_ack)
      else $error("ack without mapped access");
   a_rdata_idle: assert property (!reg_ack |-> reg_rdata == 32'h0)
      else $error("read data not zero outside ack");
   a_cfg_wo_bits: assert property (reg_ack && $past(reg_rd) &&
      $past(ofs) == `PCDC_OFS_CFG |-> reg_rdata[2:0] == 3'h0)
      else $error("config write-only bits read nonzero");
   a_stat_upper: assert property (reg_ack && $past(reg_rd) &&
      $past(ofs) == `PCDC_OFS_STAT |-> reg_rdata[31:2] == 30'h0)
      else $error("status reserved bits nonzero");
   a_count_low: assert property (reg_ack && $past(reg_rd) &&
      $past(ofs) == `PCDC_OFS_COUNT |-> reg_rdata[7:0] == 8'h00)
      else $error("count low byte nonzero");
   a_host_rd_zero: assert property (host0_rdata == 8'h00 &&
      host1_rdata == 8'h00)
      else $error("host data read nonzero");
   a_irq_idle0: assert property (ce && !activate0 |=> !fill_level_irq0)
      else $error("port 0 irq while inactive");
   a_irq_idle1: assert property (ce && !activate1 |=> !fill_level_irq1)
      else $error("port 1 irq while inactive");
   a_reset_quiet: assert property (disable iff (1'b0)
      !rstn && ce |=> !reg_ack && !fill_level_irq0 && !fill_level_irq1)
      else $error("outputs active after reset");
endmodule

bind pcdc_top pcdc_checker pcdc_checker_inst (.sys_clk, .rstn, .ce,
   .activate0, .activate1, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
   .reg_ack, .host0_rdata, .host1_rdata, .fill_level_irq0,
   .fill_level_irq1);
`default_nettype wire

// [sim/pcdc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
// host writer of post codes plus the 48 MHz oscillator tick source
module pcdc_host_model (
   input wire logic sys_clk, // system clock
   output logic ring_tick, // oscillator tick
   output logic host0_wr, // port 0 strobe
   output logic [7:0] host0_data, // port 0 byte
   output logic host1_wr, // port 1 strobe
   output logic [7:0] host1_data // port 1 byte
);
   logic run;
   logic [4:0] acc;
   initial begin
      {run, ring_tick, host0_wr, host1_wr, acc} = 9'h000;
      host0_data = 8'h00;
      host1_data = 8'h00;
   end
   // 6 ticks per 25 clocks; ticks only while the bench lets it run
   always @(negedge sys_clk) begin
      acc <= (acc >= 5'h13) ? acc - 5'h13 : acc + 5'h06;
      ring_tick <= run && (acc >= 5'h13);
   end
   // one byte; lines flip afterwards so a stale byte never passes
   task send(input logic p, input logic [7:0] b);
      @(negedge sys_clk);
      if (p) {host1_wr, host1_data} = {1'b1, b};
      else {host0_wr, host0_data} = {1'b1, b};
      @(negedge sys_clk);
      {host0_wr, host1_wr} = 2'h0;
      host0_data = ~host0_data;
      host1_data = ~host1_data;
   endtask
endmodule
`default_nettype wire

// [sim/pcdc_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pcdc_regs.vh"
// self-checking bench for the two-port code capture block
module pcdc_top_tb;
   logic sys_clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic ce = 1'b1;
   logic [1:0] act = 2'h0;
   logic [31:0] reg_addr = 32'h0, reg_wdata = 32'h0, v, cf, q[$];
   logic [23:0] ts;
   wire tick, h0w, h1w, ack, irq0, irq1;
   wire [7:0] h0d, h1d;
   wire [31:0] rdata;
   integer mismatches = 0, n_compared = 0, seed = 82, tcnt = 0;
   integer i, k, n, p;

   always #2.5 sys_clk = ~sys_clk;
   // ticks the design actually samples
   always @(posedge sys_clk) if (tick) tcnt <= tcnt + 1;

   pcdc_host_model pcdc_host_model_inst (.sys_clk(sys_clk),
      .ring_tick(tick), .host0_wr(h0w), .host0_data(h0d),
      .host1_wr(h1w), .host1_data(h1d));
   pcdc_top pcdc_top_inst (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
      .ring_tick(tick), .activate0(act[0]), .host0_wr(h0w),
      .host0_data(h0d), .host0_rdata(), .activate1(act[1]),
      .host1_wr(h1w), .host1_data(h1d), .host1_rdata(),
      .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(rdata), .reg_ack(ack),
      .fill_level_irq0(irq0), .fill_level_irq1(irq1));

   task chk(input logic [31:0] s, input logic [31:0] e);
      n_compared = n_compared + 1;
      if (s !== e) begin
         mismatches = mismatches + 1;
         $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // one ec access; answer taken in the cycle after the strobe
   task acc(input logic w, input integer pp, input integer o,
      input logic [31:0] d);
      @(negedge sys_clk);
      reg_addr = (pp ? `PCDC_BASE1 : `PCDC_BASE0) + `PCDC_OFS_DATA + o;
      {reg_wr, reg_rd, reg_wdata} = {w, !w, d};
      @(negedge sys_clk);
      {reg_wr, reg_rd} = 2'h0;
      v = rdata;
      chk(ack, o < 16);
   endtask
   task wr(input integer pp, input integer o, input logic [31:0] d);
      acc(1'b1, pp, o, d);
   endtask
   task rd(input integer pp, input integer o);
      acc(1'b0, pp, o, 32'h0);
   endtask
   function integer thr(input integer c);
      thr = (c == 0) ? 1 : (c == 1) ? 4 : (c == 2) ? 8 : 14;
   endfunction
   task tally_and_finish;
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (2) @(negedge sys_clk);
      rstn = 1'b1;
      for (p = 0; p < 2; p++) for (k = 0; k <= 16; k = k + 4) begin
         rd(p, k);
         chk(v, 32'h0);
      end
      act = 2'h3;
      $display("test reset done");
      for (p = 0; p < 2; p++) begin
         ts = $random(seed);
         wr(p, 12, {ts, 8'h00});
         rd(p, 12);
         chk(v, {ts, 8'h00});
         wr(p, 12, 32'h0);
         rd(p, 12);
         chk(v, 32'h0);
         wr(p, 12, {ts, 8'hFF});
         wr(p, 4, 32'h04);
         rd(p, 12);
         chk(v, 32'h0);
         rd(p, 4);
         chk(v, 32'h0);
         wr(p, 12, {ts, 8'h00});
         q = {};
         for (i = 0; i < 17; i++) begin
            k = $random(seed);
            q.push_back({ts, k[7:0]});
            pcdc_host_model_inst.send(p[0], k[7:0]);
         end
         void'(q.pop_front());
         rd(p, 8);
         chk(v, 32'h3);
         for (i = 0; i < 16; i++) begin
            rd(p, 0);
            chk(v, q.pop_front());
         end
         rd(p, 8);
         chk(v, 32'h2);
         rd(p, 0);
         chk(v, 32'h0);
         pcdc_host_model_inst.send(p[0], 8'h5A);
         wr(p, 4, 32'h02);
         rd(p, 8);
         chk(v, 32'h0);
         // frozen clock enable: a host byte must not be queued
         @(negedge sys_clk);
         ce = 1'b0;
         pcdc_host_model_inst.send(p[0], 8'hA5);
         ce = 1'b1;
         rd(p, 8);
         chk(v, 32'h0);
      end
      $display("test fifo done");
      for (k = 0; k < 4; k++) begin
         p = {$random(seed)} % 2;
         wr(p, 4, {k[1:0], 6'h02});
         for (i = 1; i <= 14; i++) begin
            pcdc_host_model_inst.send(p[0], i[7:0]);
            @(negedge sys_clk);
            chk(p ? irq1 : irq0, i >= thr(k));
         end
      end
      $display("test threshold done");
      // inactive spell zeroes the prescaler before each rate run
      for (k = 0; k < 4; k++) begin
         p = {$random(seed)} % 2;
         cf = {2'h0, 1'b1, k[1:0], 3'h0};
         act[p] = 1'b0;
         @(negedge sys_clk);
         act[p] = 1'b1;
         wr(p, 4, cf);
         n = tcnt;
         pcdc_host_model_inst.run <= 1'b1;
         for (i = 0; i < 4000 && tcnt < n + (28 << k); i++)
            @(negedge sys_clk);
         pcdc_host_model_inst.run <= 1'b0;
         repeat (3) @(negedge sys_clk);
         rd(p, 12);
         chk(v, ((tcnt - n) >> (k + 3)) << 8);
         // timer enable off: ticks keep coming, count must hold
         ts = (tcnt - n) >> (k + 3);
         cf[5] = 1'b0;
         wr(p, 4, cf);
         pcdc_host_model_inst.run <= 1'b1;
         repeat (100) @(negedge sys_clk);
         pcdc_host_model_inst.run <= 1'b0;
         rd(p, 12);
         chk(v, {ts, 8'h00});
         act[p] = 1'b0;
         pcdc_host_model_inst.send(p[0], 8'hC3);
         rd(p, 8);
         chk(v, 32'h0);
         rd(p, 12);
         chk(v, 32'h0);
         rd(p, 4);
         chk(v, cf);
         act[p] = 1'b1;
         @(negedge sys_clk);
      end
      $display("test timer done");
      tally_and_finish;
   end

   // hang guard, well beyond the expected run length
   initial begin
      #400000;
      mismatches = mismatches + 1;
      tally_and_finish;
   end
endmodule
`default_nettype wire
